// >>> conv_setup_pkg.sv
// constants, register map and types for the converter setup block
package conv_setup_pkg;
  localparam logic [7:0] ADDR_CH0_RESULT = 8'h00;
  localparam logic [7:0] ADDR_CH1_RESULT = 8'h02;
  localparam logic [7:0] ADDR_CONV_LEN   = 8'h08;
  localparam logic [7:0] ADDR_SETTLE_LEN = 8'h10;
  localparam logic [7:0] ADDR_DIVIDERS   = 8'h14;
  localparam logic [7:0] ADDR_FAULT_MASK = 8'h19;
  localparam logic [7:0] ADDR_MAIN_SETUP = 8'h1A;
  localparam logic [7:0] ADDR_SEQ_SETUP  = 8'h1B;
  localparam logic [7:0] ADDR_DRIVE      = 8'h1E;
  localparam logic [15:0] RST_CONV_LEN   = 16'h0080;
  localparam logic [15:0] RST_SETTLE_LEN = 16'h0080;
  localparam logic [15:0] RST_DIVIDERS   = 16'h1001;
  localparam logic [15:0] RST_FAULT_MASK = 16'h0000;
  localparam logic [15:0] RST_MAIN_SETUP = 16'h2801;
  localparam logic [15:0] RST_SEQ_SETUP  = 16'h020F;
  localparam logic [15:0] RST_DRIVE      = 16'h0000;
  localparam int MAIN_CHAN_LO  = 14;
  localparam int MAIN_SLEEP    = 13;
  localparam int MAIN_OVERRIDE = 12;
  localparam int MAIN_ACT_SEL  = 11;
  localparam int MAIN_AMP_OFF  = 10;
  localparam int MAIN_REF_SRC  = 9;
  localparam int MAIN_IRQ_DIS  = 7;
  localparam int SEQ_SCAN      = 15;
  localparam int SEQ_GROUP_LO  = 13;
  localparam int FAULT_RDY_IRQ = 0;
  localparam int DIV_FIN_LO    = 12;
  localparam int DRV_STEADY_LO = 11;
  localparam int DRV_INIT_LO   = 6;
  localparam logic [1:0] GROUP_CH01 = 2'b00;
  localparam logic [4:0] FULL_DRIVE = 5'h1F;
  localparam logic [20:0] PERIOD_MULT = 21'd16;
  localparam int SWITCH_NS      = 1000;
  localparam int SWITCH_REF_MHZ = 20;
  localparam logic [20:0] SWITCH_TICKS = 21'(SWITCH_NS * SWITCH_REF_MHZ / 1000);
  localparam logic [3:0] LAST_BIT = 4'd8;
  localparam logic [3:0] ACK_BIT  = 4'd9;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } reg_write_t;
  typedef enum logic [3:0] {
    S_SLEEP  = 4'b0001,
    S_SETTLE = 4'b0010,
    S_CONV   = 4'b0100,
    S_SWITCH = 4'b1000
  } seq_state_t;
  typedef enum logic [4:0] {
    B_IDLE  = 5'b00001,
    B_ADDR  = 5'b00010,
    B_PTR   = 5'b00100,
    B_WRITE = 5'b01000,
    B_READ  = 5'b10000
  } bus_state_t;
endpackage : conv_setup_pkg

// >>> conv_setup.sv
// converter setup, sequencing and serial register slave
`timescale 1ns/1ps
module conv_setup #(
  parameter logic [6:0] DEV_ADDR    = 7'h2A,
  parameter int         INT_OSC_DIV = 2
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       external_reference_input,
  input  wire logic [1:0] sensor_in,
  output logic            interrupt_out_n,
  output logic            converting,
  output logic            active_channel,
  output logic [4:0]      sensor_drive,
  output logic            calibration_en,
  output logic            amplitude_correction_en,
  output logic [2:0]      deglitch_select
);
  import conv_setup_pkg::*;

  // DEV_ADDR is an arbitrary value
  if (INT_OSC_DIV < 1 || INT_OSC_DIV > 255) begin : g_bad_div
    $error("INT_OSC_DIV must lie in 1..255");
  end

  logic [4:0]  sync1_reg, sync2_reg, prev_reg;
  logic [15:0] conv_len_reg, settle_len_reg, div_reg, fault_reg;
  logic [15:0] main_reg, seq_reg, drive_reg, ch0_res_reg, ch1_res_reg;
  logic [7:0]  osc_cnt_reg;
  logic [9:0]  fdiv_cnt_reg;
  logic [3:0]  pre_cnt_reg;
  logic [15:0] sense_cnt_reg;
  logic [20:0] tmr_reg;
  logic        chan_reg, irq_n_reg, conv_out_reg, cal_reg, amp_reg;
  logic [4:0]  drv_out_reg;
  seq_state_t  state_reg;
  bus_state_t  bst_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg, ptr_reg, hold_reg;
  logic [15:0] tx_reg;
  logic        byte_hi_reg, sda_oe_reg, wr_pulse_reg, rd_clr_reg;
  reg_write_t  wr_reg;

  // only the second stage is read; prev_reg gives edges
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 5'h1F;
      sync2_reg <= 5'h1F;
      prev_reg  <= 5'h1F;
    end else begin
      sync1_reg <= {scl_in, sda_in, external_reference_input, sensor_in};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire scl_s     = sync2_reg[4];
  wire sda_s     = sync2_reg[3];
  wire scl_rise  = scl_s & ~prev_reg[4];
  wire scl_fall  = ~scl_s & prev_reg[4];
  wire bus_start = scl_s & prev_reg[4] & prev_reg[3] & ~sda_s;
  wire bus_stop  = scl_s & prev_reg[4] & ~prev_reg[3] & sda_s;
  wire ext_rise  = sync2_reg[2] & ~prev_reg[2];
  wire [1:0] sense_rise = sync2_reg[1:0] & ~prev_reg[1:0];

  wire       sleep_en  = main_reg[MAIN_SLEEP];
  wire       scan_en   = seq_reg[SEQ_SCAN];
  wire [3:0] fin_div   = (div_reg[15:DIV_FIN_LO] == 4'h0) ? 4'h1 : div_reg[15:DIV_FIN_LO];
  wire [9:0] fref_div  = (div_reg[9:0] == 10'h000) ? 10'h001 : div_reg[9:0];
  wire       osc_tick  = osc_cnt_reg == 8'(INT_OSC_DIV - 1);
  wire       clk_tick  = main_reg[MAIN_REF_SRC] ? ext_rise : osc_tick;
  wire       ref_tick  = clk_tick && (fdiv_cnt_reg >= fref_div - 10'h001);
  wire       tmr_done  = ref_tick && (tmr_reg <= 21'd1);
  wire [20:0] settle_ticks = 21'(settle_len_reg) * PERIOD_MULT;
  wire [20:0] conv_ticks   = 21'(conv_len_reg) * PERIOD_MULT;
  wire       first_chan = scan_en ? 1'b0 : main_reg[MAIN_CHAN_LO];
  // scan stepping; group 00 alternates 0 and 1
  wire       next_chan  = (scan_en && seq_reg[14:SEQ_GROUP_LO] == GROUP_CH01) ? ~chan_reg
                        : (scan_en ? ~chan_reg : chan_reg);
  wire       last_chan  = ~scan_en | chan_reg;
  wire       conv_end   = (state_reg == S_CONV) && tmr_done;
  // ready interrupt; mask default keeps it off
  wire       irq_set    = conv_end && last_chan && fault_reg[FAULT_RDY_IRQ]
                        && !main_reg[MAIN_IRQ_DIS];
  wire       wr_ok      = wr_pulse_reg && (sleep_en || wr_reg.addr == ADDR_MAIN_SETUP);
  wire [7:0] ptr_inc    = ptr_reg + 8'h01;

  function automatic logic [15:0] read_reg(input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a == ADDR_CH0_RESULT) v = ch0_res_reg;
    else if (a == ADDR_CH1_RESULT) v = ch1_res_reg;
    else if (a == ADDR_CONV_LEN) v = conv_len_reg;
    else if (a == ADDR_SETTLE_LEN) v = settle_len_reg;
    else if (a == ADDR_DIVIDERS) v = div_reg;
    else if (a == ADDR_FAULT_MASK) v = fault_reg;
    else if (a == ADDR_MAIN_SETUP) v = main_reg;
    else if (a == ADDR_SEQ_SETUP) v = seq_reg;
    else if (a == ADDR_DRIVE) v = drive_reg;
    return v;
  endfunction : read_reg

  function automatic logic is_result(input logic [7:0] a);
    return a == ADDR_CH0_RESULT || a == ADDR_CH1_RESULT;
  endfunction : is_result

  // serial slave: pointer byte, then 16-bit words high byte first
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bst_reg <= B_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      hold_reg <= 8'h00;
      tx_reg <= 16'h0000;
      byte_hi_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      rd_clr_reg <= 1'b0;
      wr_reg <= '0;
    end else begin
      wr_pulse_reg <= 1'b0;
      rd_clr_reg <= 1'b0;
      if (bus_start) begin
        bst_reg <= B_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end else if (bus_stop) begin
        bst_reg <= B_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (bst_reg != B_IDLE && scl_rise && bit_cnt_reg < ACK_BIT) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= {shift_reg[6:0], sda_s};
        if (bst_reg == B_READ && bit_cnt_reg < LAST_BIT) tx_reg <= {tx_reg[14:0], 1'b0};
        if (bst_reg == B_READ && bit_cnt_reg == LAST_BIT && sda_s) bst_reg <= B_IDLE;
      end else if (bst_reg != B_IDLE && scl_fall) begin
        if (bit_cnt_reg == ACK_BIT) begin
          bit_cnt_reg <= 4'h0;
          sda_oe_reg <= (bst_reg == B_READ) && !tx_reg[15];
        end else if (bit_cnt_reg == LAST_BIT) begin
          sda_oe_reg <= 1'b1;
          if (bst_reg == B_ADDR) begin
            if (shift_reg[7:1] == DEV_ADDR) begin
              bst_reg <= shift_reg[0] ? B_READ : B_PTR;
              tx_reg <= read_reg(ptr_reg);
              byte_hi_reg <= 1'b1;
              rd_clr_reg <= shift_reg[0] && is_result(ptr_reg);
            end else begin
              bst_reg <= B_IDLE;
              sda_oe_reg <= 1'b0;
            end
          end else if (bst_reg == B_PTR) begin
            ptr_reg <= shift_reg;
            bst_reg <= B_WRITE;
            byte_hi_reg <= 1'b1;
          end else if (bst_reg == B_WRITE) begin
            byte_hi_reg <= ~byte_hi_reg;
            if (byte_hi_reg) hold_reg <= shift_reg;
            else begin
              wr_reg <= '{addr: ptr_reg, data: {hold_reg, shift_reg}};
              wr_pulse_reg <= 1'b1;
              ptr_reg <= ptr_inc;
            end
          end else begin
            sda_oe_reg <= 1'b0;
            byte_hi_reg <= ~byte_hi_reg;
            if (!byte_hi_reg) begin
              ptr_reg <= ptr_inc;
              tx_reg <= read_reg(ptr_inc);
              rd_clr_reg <= is_result(ptr_inc);
            end
          end
        end else if (bst_reg == B_READ) begin
          sda_oe_reg <= !tx_reg[15];
        end
      end
    end
  end

  // register writes; deglitch code kept for all channels
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      conv_len_reg <= RST_CONV_LEN;
      settle_len_reg <= RST_SETTLE_LEN;
      div_reg <= RST_DIVIDERS;
      fault_reg <= RST_FAULT_MASK;
      main_reg <= RST_MAIN_SETUP;
      seq_reg <= RST_SEQ_SETUP;
      drive_reg <= RST_DRIVE;
    end else if (wr_ok) begin
      if (wr_reg.addr == ADDR_CONV_LEN) conv_len_reg <= wr_reg.data;
      else if (wr_reg.addr == ADDR_SETTLE_LEN) settle_len_reg <= wr_reg.data;
      else if (wr_reg.addr == ADDR_DIVIDERS) div_reg <= wr_reg.data;
      else if (wr_reg.addr == ADDR_FAULT_MASK) fault_reg <= wr_reg.data;
      else if (wr_reg.addr == ADDR_MAIN_SETUP) main_reg <= wr_reg.data;
      else if (wr_reg.addr == ADDR_SEQ_SETUP) seq_reg <= wr_reg.data;
      else if (wr_reg.addr == ADDR_DRIVE) drive_reg <= wr_reg.data;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      osc_cnt_reg <= 8'h00;
      fdiv_cnt_reg <= 10'h000;
    end else begin
      osc_cnt_reg <= osc_tick ? 8'h00 : osc_cnt_reg + 8'h01;
      if (ref_tick) fdiv_cnt_reg <= 10'h000;
      else if (clk_tick) fdiv_cnt_reg <= fdiv_cnt_reg + 10'h001;
    end
  end

  // sleep at reset; leave sleep when cleared; switch gap
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_SLEEP;
      tmr_reg <= 21'd0;
      chan_reg <= 1'b0;
    end else if (sleep_en) begin
      state_reg <= S_SLEEP;
    end else begin
      case (state_reg)
        S_SLEEP: begin
          state_reg <= S_SETTLE;
          tmr_reg <= settle_ticks;
          chan_reg <= first_chan;
        end
        S_SETTLE: if (tmr_done) begin
          state_reg <= S_CONV;
          tmr_reg <= conv_ticks;
        end else if (ref_tick) tmr_reg <= tmr_reg - 21'd1;
        S_CONV: if (tmr_done) begin
          state_reg <= S_SWITCH;
          tmr_reg <= SWITCH_TICKS;
          chan_reg <= next_chan;
        end else if (ref_tick) tmr_reg <= tmr_reg - 21'd1;
        S_SWITCH: if (tmr_done) begin
          state_reg <= S_SETTLE;
          tmr_reg <= settle_ticks;
        end else if (ref_tick) tmr_reg <= tmr_reg - 21'd1;
        default: state_reg <= S_SLEEP;
      endcase
    end
  end

  // sensor edges counted after the input divider; saturates rather than wraps
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_reg <= 4'h0;
      sense_cnt_reg <= 16'h0000;
      ch0_res_reg <= 16'h0000;
      ch1_res_reg <= 16'h0000;
    end else if (state_reg == S_SLEEP) begin
      pre_cnt_reg <= 4'h0;
      sense_cnt_reg <= 16'h0000;
      ch0_res_reg <= 16'h0000;
      ch1_res_reg <= 16'h0000;
    end else if (state_reg != S_CONV) begin
      pre_cnt_reg <= 4'h0;
      sense_cnt_reg <= 16'h0000;
    end else begin
      if (conv_end && !chan_reg) ch0_res_reg <= sense_cnt_reg;
      if (conv_end && chan_reg) ch1_res_reg <= sense_cnt_reg;
      if (sense_rise[chan_reg]) begin
        if (pre_cnt_reg >= fin_div - 4'h1) begin
          pre_cnt_reg <= 4'h0;
          if (sense_cnt_reg != 16'hFFFF) sense_cnt_reg <= sense_cnt_reg + 16'h0001;
        end else pre_cnt_reg <= pre_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_n_reg <= 1'b1;
      conv_out_reg <= 1'b0;
      cal_reg <= 1'b0;
      amp_reg <= 1'b0;
      drv_out_reg <= 5'h00;
    end else begin
      // set wins over a same-cycle clear
      if (irq_set) irq_n_reg <= 1'b0;
      else if (sleep_en || rd_clr_reg || main_reg[MAIN_IRQ_DIS]) irq_n_reg <= 1'b1;
      conv_out_reg <= state_reg == S_CONV;
      cal_reg <= !sleep_en && !main_reg[MAIN_OVERRIDE];
      amp_reg <= !sleep_en && !main_reg[MAIN_AMP_OFF];
      // full drive while activating when select is 0
      if (state_reg == S_SETTLE)
        drv_out_reg <= main_reg[MAIN_ACT_SEL] ? drive_reg[10:DRV_INIT_LO] : FULL_DRIVE;
      else if (state_reg == S_SLEEP) drv_out_reg <= 5'h00;
      else drv_out_reg <= drive_reg[15:DRV_STEADY_LO];
    end
  end

  // the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign interrupt_out_n = irq_n_reg;
  assign converting = conv_out_reg;
  assign active_channel = chan_reg;
  assign sensor_drive = drv_out_reg;
  assign calibration_en = cal_reg;
  assign amplitude_correction_en = amp_reg;
  assign deglitch_select = seq_reg[2:0];

  sequence conv_finish;
    state_reg == S_CONV && tmr_done;
  endsequence
  sequence enter_switch;
    ##1 state_reg == S_SWITCH && tmr_reg == SWITCH_TICKS;
  endsequence

  a_sleep_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
    sleep_en |=> state_reg == S_SLEEP ##1 !converting) else $error("converter active in sleep");
  a_settle_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_reg == S_SLEEP && !sleep_en) |=> tmr_reg == $past(settle_ticks))
    else $error("settle length wrong");
  a_conv_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_reg == S_SETTLE && tmr_done && !sleep_en) |=> state_reg == S_CONV
    && tmr_reg == 21'(conv_len_reg) * PERIOD_MULT) else $error("conversion length wrong");
  a_switch_gap: assert property (@(posedge clk_sys) disable iff (!nrst)
    conv_finish and !sleep_en |-> enter_switch) else $error("switch delay missing");
  a_no_irq_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!fault_reg[FAULT_RDY_IRQ] && interrupt_out_n) |=> interrupt_out_n)
    else $error("interrupt while masked");
  a_scan_alternates: assert property (@(posedge clk_sys) disable iff (!nrst)
    (conv_finish and scan_en && !sleep_en) |=> chan_reg != $past(chan_reg))
    else $error("scan did not alternate");
  a_ext_source: assert property (@(posedge clk_sys) disable iff (!nrst)
    (main_reg[MAIN_REF_SRC] && !ext_rise && state_reg == S_CONV && !sleep_en) |=>
    (state_reg == S_CONV && $stable(tmr_reg))) else $error("wrong reference source");
  a_refuse_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_pulse_reg && !sleep_en && wr_reg.addr == ADDR_CONV_LEN) |=> $stable(conv_len_reg))
    else $error("write accepted while awake");
  a_ready_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
    irq_set |=> !interrupt_out_n) else $error("ready interrupt not raised");
  a_full_activation: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_reg == S_SETTLE && !main_reg[MAIN_ACT_SEL] && !sleep_en)[*2] |->
    sensor_drive == FULL_DRIVE) else $error("activation drive not full");
endmodule : conv_setup

// >>> conv_host_model.sv
// serial bus host model that programs and reads the converter setup block
`timescale 1ns/1ps
module conv_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  logic nacked = 1'b0;
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : gap
  // start or repeated start: data falls while the clock is high
  task automatic start;
    sda_low <= 1'b0;
    gap(4);
    scl <= 1'b1;
    gap(6);
    sda_low <= 1'b1;
    gap(6);
    scl <= 1'b0;
    gap(2);
  endtask : start
  task automatic stop;
    sda_low <= 1'b1;
    gap(4);
    scl <= 1'b1;
    gap(6);
    sda_low <= 1'b0;
    gap(8);
  endtask : stop
  // data moves only while the clock is low; phases of 6 clocks clear the 4 clock minimum
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= ~tx[i];
      gap(4);
      scl <= 1'b1;
      gap(6);
      rx[i] = sda_line;
      scl <= 1'b0;
      gap(2);
    end
  endtask : xfer
  task automatic wbyte(input logic [7:0] b);
    logic [8:0] rx;
    xfer({b, 1'b1}, rx);
    if (rx[0]) begin
      nacked = 1'b1;
    end
  endtask : wbyte
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    start();
    wbyte({DEV_ADDR, 1'b0});
    wbyte(addr);
    wbyte(data[15:8]);
    wbyte(data[7:0]);
    stop();
  endtask : write_reg
  // word read: acknowledge the high byte, refuse after the low byte to end
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
    logic [8:0] hi;
    logic [8:0] lo;
    start();
    wbyte({DEV_ADDR, 1'b0});
    wbyte(addr);
    start();
    wbyte({DEV_ADDR, 1'b1});
    xfer(9'h1FE, hi);
    xfer(9'h1FF, lo);
    stop();
    data = {hi[8:1], lo[8:1]};
  endtask : read_reg
endmodule : conv_host_model

// >>> inductive_sensor_conversion_setup_tb_top.sv
// self-checking bench for the converter setup block
`timescale 1ns/1ps
module inductive_sensor_conversion_setup_tb_top;
  import conv_setup_pkg::*;
  localparam int OSC_DIV = 2;
  localparam int LIM     = 20000;
  logic        clk_sys;
  logic        nrst;
  logic        scl;
  logic        sda_low;
  logic        sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic        external_reference_input = 1'b0;
  logic [1:0]  sensor_in = 2'h0;
  logic        interrupt_out_n;
  logic        converting;
  logic        active_channel;
  logic [4:0]  sensor_drive;
  logic        calibration_en;
  logic        amplitude_correction_en;
  logic [2:0]  deglitch_select;
  logic [1:0]  phase;
  logic [7:0]  reg_a [9];
  logic [15:0] reg_d [9];
  int          errors;
  int          n_compared;
  int          conv_v;
  int          settle_v;
  int          s0_per = 30;
  int          s1_per = 40;
  int          ref_cnt;
  int          s0_cnt;
  int          s1_cnt;

  conv_setup #(.INT_OSC_DIV(OSC_DIV)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .external_reference_input(external_reference_input),
    .sensor_in(sensor_in), .interrupt_out_n(interrupt_out_n), .converting(converting),
    .active_channel(active_channel), .sensor_drive(sensor_drive),
    .calibration_en(calibration_en), .amplitude_correction_en(amplitude_correction_en),
    .deglitch_select(deglitch_select));
  conv_host_model host_u (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  // open drain data line with pull-up
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
  assign phase = converting ? 2'h2 : (sensor_drive == FULL_DRIVE) ? 2'h1 : 2'h0;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // sensors below a quarter of reference
  always @(posedge clk_sys) begin
    ref_cnt                  <= (ref_cnt + 1) % 6;
    s0_cnt                   <= (s0_cnt + 1) % s0_per;
    s1_cnt                   <= (s1_cnt + 1) % s1_per;
    external_reference_input <= (ref_cnt < 3);
    sensor_in                <= {s1_cnt < s1_per / 2, s0_cnt < s0_per / 2};
  end

  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic expect_val(input logic [15:0] got, input logic [15:0] exp, input int tol = 0);
    n_compared++;
    if ($isunknown(got) || int'(got) > int'(exp) + tol || int'(got) + tol < int'(exp)) begin
      errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : expect_val
  // count edges while the phase is (or is not) p; a stuck phase ends the run
  task automatic run(input logic [1:0] p, input logic stay, output int n);
    n = 0;
    while ((phase === p) == stay && n < LIM) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= LIM) begin
      errors++;
      tally_and_finish();
    end
  endtask : run
  // wake, then time conversion, switch and the next settle
  task automatic one_round(input logic [15:0] main_v, input int tick, input logic ch2);
    int n;
    host_u.write_reg(ADDR_MAIN_SETUP, main_v);
    run(2'h2, 1'b0, n);
    expect_val(16'(sensor_drive), 16'h0012);
    expect_val(16'(deglitch_select), 16'h0004);
    expect_val({14'h0000, calibration_en, amplitude_correction_en}, 16'h0000);
    expect_val(16'(active_channel), 16'h0000);
    run(2'h2, 1'b1, n);
    expect_val(16'(n), 16'(conv_v * 16 * tick), 3);
    run(2'h0, 1'b1, n);
    expect_val(16'(n), 16'(20 * tick), 3);
    run(2'h1, 1'b1, n);
    expect_val(16'(n), 16'(settle_v * 16 * tick), 3);
    run(2'h2, 1'b0, n);
    expect_val(16'(active_channel), 16'(ch2));
  endtask : one_round

  initial begin
    logic [15:0] rd;
    nrst       = 1'b0;
    errors     = 0;
    n_compared = 0;
    void'($urandom(46));
    s0_per   = 30 + int'($urandom % 10);
    s1_per   = 40 + int'($urandom % 20);
    conv_v   = 1 + int'($urandom % 3);
    settle_v = 2 + int'($urandom % 3);
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    expect_val({14'h0000, converting, |sensor_drive}, 16'h0000);
    reg_a = '{ADDR_CONV_LEN, ADDR_SETTLE_LEN, ADDR_DIVIDERS, ADDR_FAULT_MASK, ADDR_SEQ_SETUP,
              ADDR_DRIVE, ADDR_MAIN_SETUP, ADDR_CH1_RESULT, 8'h05};
    reg_d = '{RST_CONV_LEN, RST_SETTLE_LEN, RST_DIVIDERS, RST_FAULT_MASK, RST_SEQ_SETUP,
              RST_DRIVE, RST_MAIN_SETUP, 16'h0000, 16'h0000};
    for (int i = 0; i < 9; i++) begin
      host_u.read_reg(reg_a[i], rd);
      expect_val(rd, reg_d[i]);
    end
    // input divider one, fault mask left at default
    reg_d[0:5] = '{16'(conv_v), 16'(settle_v), 16'h1001, 16'h0000, 16'h820C, 16'h9000};
    for (int i = 0; i < 6; i++) begin
      host_u.write_reg(reg_a[i], reg_d[i]);
    end
    for (int i = 0; i < 6; i++) begin
      host_u.read_reg(reg_a[i], rd);
      expect_val(rd, reg_d[i]);
    end
    // main setup last: wake with override, amplitude off, external reference
    one_round(16'h1601, 6, 1'b1);
    host_u.read_reg(ADDR_CH0_RESULT, rd);
    expect_val(rd, 16'(conv_v * 96 / s0_per), 1);
    host_u.read_reg(ADDR_CH1_RESULT, rd);
    expect_val(rd, 16'(conv_v * 96 / s1_per), 1);
    expect_val(16'(interrupt_out_n), 16'h0001);
    host_u.write_reg(ADDR_CONV_LEN, 16'h0055);
    host_u.read_reg(ADDR_CONV_LEN, rd);
    expect_val(rd, 16'(conv_v));
    // long conversion leaves room for a read before the next interrupt
    host_u.write_reg(ADDR_MAIN_SETUP, 16'h3601);
    conv_v = 64;
    host_u.write_reg(ADDR_CONV_LEN, 16'h0040);
    host_u.write_reg(ADDR_SEQ_SETUP, 16'h020C);
    host_u.write_reg(ADDR_FAULT_MASK, 16'h0001);
    one_round(16'h1401, OSC_DIV, 1'b0);
    expect_val(16'(interrupt_out_n), 16'h0000);
    host_u.read_reg(ADDR_CH0_RESULT, rd);
    expect_val(16'(interrupt_out_n), 16'h0001);
    expect_val(16'(host_u.nacked), 16'h0000);
    tally_and_finish();
  end
endmodule : inductive_sensor_conversion_setup_tb_top
